// *** verilog/phy_regs_pkg.sv ***
// Constants, field positions and carrier types for the physical-layer register bank.
// Assumes an APB master with 32-bit data; registers sit in the low 16 bits of a word.
`default_nettype none

package phy_regs_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned REG_W = 16;

    // Printed offsets are register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_RESET = 12'h0_0d8;
    localparam logic [ADDR_W-1:0] IDX_CTRL = 12'h0_0e4;
    localparam logic [ADDR_W-1:0] IDX_STAT = 12'h0_0e6;
    localparam logic [ADDR_W-1:0] IDX_ID_LOW = 12'h0_0e8;
    localparam logic [ADDR_W-1:0] IDX_ID_HIGH = 12'h0_0ea;
    localparam logic [ADDR_W-1:0] IDX_ADVERT = 12'h0_0ec;
    localparam logic [ADDR_W-1:0] ADDR_RESET = IDX_RESET << 2;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = IDX_CTRL << 2;
    localparam logic [ADDR_W-1:0] ADDR_STAT = IDX_STAT << 2;
    localparam logic [ADDR_W-1:0] ADDR_ID_LOW = IDX_ID_LOW << 2;
    localparam logic [ADDR_W-1:0] ADDR_ID_HIGH = IDX_ID_HIGH << 2;
    localparam logic [ADDR_W-1:0] ADDR_ADVERT = IDX_ADVERT << 2;

    localparam int unsigned BIT_PHY_RESET = 0;

    localparam int unsigned BIT_LOOPBACK = 14;
    localparam int unsigned BIT_SPEED_100 = 13;
    localparam int unsigned BIT_AN_ENABLE = 12;
    localparam int unsigned BIT_AN_RESTART = 9;
    localparam int unsigned BIT_FULL_DUPLEX = 8;
    localparam int unsigned BIT_XOVER_ALG = 5;
    localparam int unsigned BIT_FORCE_MDIX = 4;
    localparam int unsigned BIT_NO_AUTO_MDIX = 3;
    localparam int unsigned BIT_TX_DISABLE = 1;
    localparam int unsigned BIT_LED_DISABLE = 0;

    localparam int unsigned BIT_AN_COMPLETE = 5;
    localparam int unsigned BIT_LINK_UP = 2;

    localparam int unsigned ADV_LSB = 5;
    localparam int unsigned ADV_MSB = 10;

    localparam logic [REG_W-1:0] RESET_RSVD_INIT = 16'hffff;
    localparam logic [REG_W-1:0] CTRL_INIT = 16'h3120;
    // Stored control bits; 15, 7, 6 read zero and 9 is a pulse
    localparam logic [REG_W-1:0] CTRL_RW_MASK = 16'h7d3f;
    // Capabilities 14-11 and negotiation capable bit 3
    localparam logic [REG_W-1:0] STAT_FIXED = 16'h7808;
    localparam logic [REG_W-1:0] ADV_INIT = 16'h05e0;
    localparam logic [REG_W-1:0] ADV_RW_MASK = 16'h07e0;
    localparam logic [REG_W-1:0] ADV_SELECTOR = 16'h0001;

    typedef struct packed {
        logic phy_reset;
        logic loopback;
        logic force_speed_100;
        logic speed_forced;
        logic an_enable;
        logic an_restart;
        logic force_full_duplex;
        logic duplex_forced;
        logic crossover_algorithm_select;
        logic force_mdix;
        logic disable_auto_mdix;
        logic tx_disable;
        logic led_disable;
        logic [ADV_MSB-ADV_LSB:0] advert;
    } phy_ctrl_t;

    typedef struct packed {
        logic link_up;
        logic an_complete;
        logic an_failed;
    } phy_stat_t;

endpackage

`default_nettype wire

// *** verilog/phy_mii_control_status_regs.sv ***
// APB register bank controlling and reporting on the embedded physical layer.
// Assumes a zero-wait APB master and layer status inputs synchronous to pclk.
`default_nettype none

module phy_mii_control_status_regs
    import phy_regs_pkg::*;
#(
    // Identifier values are arbitrary
    parameter logic [REG_W-1:0] PHY_ID_LOW = 16'h5a5a,
    parameter logic [REG_W-1:0] PHY_ID_HIGH = 16'h00a5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output phy_ctrl_t phy_ctrl,
    input wire phy_stat_t phy_stat
);

    logic [REG_W-1:1] reset_rsvd;
    logic [REG_W-1:0] ctrl;
    logic [REG_W-1:0] advert;
    logic reset_pulse;
    logic restart_pulse;
    logic duplex_forced;

    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire hit_reset = paddr == ADDR_RESET;
    wire hit_ctrl = paddr == ADDR_CTRL;
    wire hit_stat = paddr == ADDR_STAT;
    wire hit_id_low = paddr == ADDR_ID_LOW;
    wire hit_id_high = paddr == ADDR_ID_HIGH;
    wire hit_advert = paddr == ADDR_ADVERT;
    wire mapped = hit_reset | hit_ctrl | hit_stat | hit_id_low | hit_id_high | hit_advert;
    wire wr = access & pwrite & mapped;

    // Byte lanes 0 and 1 carry the 16-bit register
    wire [REG_W-1:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [REG_W-1:0] wdata = pwdata[REG_W-1:0] & lane_mask;

    wire [REG_W-1:0] next_ctrl = ((ctrl & ~lane_mask) | wdata) & CTRL_RW_MASK;
    wire [REG_W-1:0] next_advert = ((advert & ~lane_mask) | wdata) & ADV_RW_MASK;
    wire [REG_W-1:1] next_reset_rsvd = (reset_rsvd & ~lane_mask[REG_W-1:1]) | wdata[REG_W-1:1];

    wire [REG_W-1:0] stat_word = STAT_FIXED
        | (REG_W'(phy_stat.an_complete) << BIT_AN_COMPLETE)
        | (REG_W'(phy_stat.link_up) << BIT_LINK_UP);

    // Restart bit reads back its pulse, so it is zero once issued
    wire [REG_W-1:0] ctrl_word = ctrl | (REG_W'(restart_pulse) << BIT_AN_RESTART);

    // Reset bit 0 is write-only and reads zero
    wire [REG_W-1:0] rd_word =
        hit_reset ? {reset_rsvd, 1'b0} :
        hit_ctrl ? ctrl_word :
        hit_stat ? stat_word :
        hit_id_low ? PHY_ID_LOW :
        hit_id_high ? PHY_ID_HIGH :
        hit_advert ? (advert | ADV_SELECTOR) :
        16'h0000;

    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup & ~pwrite) begin
            prdata <= {16'h0000, rd_word};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_rsvd <= RESET_RSVD_INIT[REG_W-1:1];
            reset_pulse <= 1'b0;
        end else begin
            if (wr & hit_reset) begin
                reset_rsvd <= next_reset_rsvd;
            end
            reset_pulse <= wr & hit_reset & wdata[BIT_PHY_RESET];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_INIT;
            restart_pulse <= 1'b0;
        end else begin
            if (wr & hit_ctrl) begin
                ctrl <= next_ctrl;
            end
            restart_pulse <= wr & hit_ctrl & wdata[BIT_AN_RESTART];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            advert <= ADV_INIT;
        end else if (wr & hit_advert) begin
            advert <= next_advert;
        end
    end

    // Duplex forcing applies when negotiation is off or has failed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duplex_forced <= 1'b0;
        end else begin
            duplex_forced <= ~ctrl[BIT_AN_ENABLE] | phy_stat.an_failed;
        end
    end

    assign phy_ctrl.phy_reset = reset_pulse;
    assign phy_ctrl.loopback = ctrl[BIT_LOOPBACK];
    assign phy_ctrl.force_speed_100 = ctrl[BIT_SPEED_100];
    assign phy_ctrl.speed_forced = ~ctrl[BIT_AN_ENABLE];
    assign phy_ctrl.an_enable = ctrl[BIT_AN_ENABLE];
    assign phy_ctrl.an_restart = restart_pulse;
    assign phy_ctrl.force_full_duplex = ctrl[BIT_FULL_DUPLEX];
    assign phy_ctrl.duplex_forced = duplex_forced;
    assign phy_ctrl.crossover_algorithm_select = ctrl[BIT_XOVER_ALG];
    assign phy_ctrl.force_mdix = ctrl[BIT_FORCE_MDIX];
    assign phy_ctrl.disable_auto_mdix = ctrl[BIT_NO_AUTO_MDIX];
    assign phy_ctrl.tx_disable = ctrl[BIT_TX_DISABLE];
    assign phy_ctrl.led_disable = ctrl[BIT_LED_DISABLE];
    assign phy_ctrl.advert = advert[ADV_MSB:ADV_LSB];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire rd_setup = setup & ~pwrite;

    a_phy_reset_pulse: assert property (
        wr & hit_reset & wdata[BIT_PHY_RESET] |=> phy_ctrl.phy_reset ##1 !phy_ctrl.phy_reset)
        else $error("layer reset pulse wrong");

    a_loopback_write: assert property (
        wr & hit_ctrl & pstrb[1] |=> phy_ctrl.loopback == $past(pwdata[BIT_LOOPBACK]))
        else $error("loopback not taken from write");

    a_speed_forced_when_off: assert property (
        $fell(phy_ctrl.an_enable) |-> phy_ctrl.speed_forced)
        else $error("speed not forced with negotiation off");

    a_an_enable_write: assert property (
        wr & hit_ctrl & pstrb[1] |=> phy_ctrl.an_enable == $past(pwdata[BIT_AN_ENABLE]))
        else $error("negotiation enable not taken");

    a_restart_self_clear: assert property (
        phy_ctrl.an_restart |=> !phy_ctrl.an_restart)
        else $error("restart pulse stuck");

    a_restart_on_write: assert property (
        wr & hit_ctrl & wdata[BIT_AN_RESTART] |=> phy_ctrl.an_restart)
        else $error("restart not issued");

    a_duplex_forced: assert property (
        !phy_ctrl.an_enable || phy_stat.an_failed |=> phy_ctrl.duplex_forced)
        else $error("duplex forcing not applied");

    a_xover_write: assert property (
        wr & hit_ctrl & pstrb[0] |=> phy_ctrl.crossover_algorithm_select == $past(pwdata[BIT_XOVER_ALG]))
        else $error("crossover select not taken");

    a_mdix_write: assert property (
        wr & hit_ctrl & pstrb[0] |=> phy_ctrl.force_mdix == $past(pwdata[BIT_FORCE_MDIX])
            && phy_ctrl.disable_auto_mdix == $past(pwdata[BIT_NO_AUTO_MDIX]))
        else $error("crossover controls not taken");

    a_tx_led_write: assert property (
        wr & hit_ctrl & pstrb[0] |=> phy_ctrl.tx_disable == $past(pwdata[BIT_TX_DISABLE])
            && phy_ctrl.led_disable == $past(pwdata[BIT_LED_DISABLE]))
        else $error("transmit or LED disable not taken");

    a_status_fixed_bits: assert property (
        rd_setup & hit_stat |=> prdata[15:11] == 5'h0f && prdata[6] == 1'b0
            && prdata[3] == 1'b1 && prdata[1:0] == 2'h0)
        else $error("status capability bits wrong");

    a_status_live_bits: assert property (
        rd_setup & hit_stat |=> prdata[BIT_AN_COMPLETE] == $past(phy_stat.an_complete)
            && prdata[BIT_LINK_UP] == $past(phy_stat.link_up))
        else $error("status live bits wrong");

    a_id_words: assert property (
        rd_setup & (hit_id_low | hit_id_high) |=>
            prdata[15:0] == ($past(hit_id_low) ? PHY_ID_LOW : PHY_ID_HIGH))
        else $error("identifier read wrong");

    a_advert_write: assert property (
        wr & hit_advert & (&pstrb[1:0]) |=> phy_ctrl.advert == $past(pwdata[ADV_MSB:ADV_LSB]))
        else $error("advertisement not taken");

    a_advert_unsupported: assert property (
        rd_setup & hit_advert |=> prdata[15:11] == 5'h00 && prdata[4:0] == 5'h01)
        else $error("unsupported advert bits not zero");

    a_err_unmapped: assert property (
        access & ~mapped
        |-> pslverr)
        else $error("unmapped access without error");

    a_err_mapped_clear: assert property (
        access & mapped
        |-> !pslverr)
        else $error("mapped access flagged as error");

    a_err_idle: assert property (
        !access
        |-> !pslverr)
        else $error("error outside access phase");

    a_no_wait: assert property (
        psel
        |-> pready)
        else $error("slave inserted a wait state");

    a_rd_unmapped_zero: assert property (
        rd_setup & ~mapped
        |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_rd_upper_zero: assert property (
        rd_setup
        |=> prdata[31:16] == 16'h0000)
        else $error("upper read half not zero");

    a_prdata_hold: assert property (
        !rd_setup
        |=> $stable(prdata))
        else $error("read data changed outside read setup");

    a_reset_reads_zero: assert property (
        rd_setup & hit_reset
        |=> prdata[BIT_PHY_RESET] == 1'b0)
        else $error("layer reset bit reads one");

    a_reset_pulse_idle: assert property (
        !(wr & hit_reset)
        |=> !phy_ctrl.phy_reset)
        else $error("layer reset pulse without write");

    a_reset_needs_bit: assert property (
        wr & hit_reset & !wdata[BIT_PHY_RESET]
        |=> !phy_ctrl.phy_reset)
        else $error("layer reset pulse on zero write");

    a_reset_rsvd_write: assert property (
        wr & hit_reset & (&pstrb[1:0])
        |=> reset_rsvd == $past(pwdata[REG_W-1:1]))
        else $error("reserved reset bits not stored");

    a_restart_idle: assert property (
        !(wr & hit_ctrl)
        |=> !phy_ctrl.an_restart)
        else $error("restart pulse without write");

    a_restart_needs_bit: assert property (
        wr & hit_ctrl & !wdata[BIT_AN_RESTART]
        |=> !phy_ctrl.an_restart)
        else $error("restart pulse on zero write");

    a_restart_reads_zero: assert property (
        rd_setup & hit_ctrl & !restart_pulse
        |=> prdata[BIT_AN_RESTART] == 1'b0)
        else $error("restart bit reads one when idle");

    a_pulses_apart: assert property (
        phy_ctrl.phy_reset
        |-> !phy_ctrl.an_restart)
        else $error("reset and restart pulses together");

    a_ctrl_reserved_zero: assert property (
        rd_setup & hit_ctrl
        |=> prdata[15] == 1'b0 && prdata[7:6] == 2'h0)
        else $error("read-only control bits not zero");

    a_ctrl_hold: assert property (
        !(wr & hit_ctrl)
        |=> $stable(ctrl))
        else $error("control changed without write");

    a_speed_write: assert property (
        wr & hit_ctrl & pstrb[1]
        |=> phy_ctrl.force_speed_100 == $past(pwdata[BIT_SPEED_100]))
        else $error("forced speed not taken");

    a_duplex_write: assert property (
        wr & hit_ctrl & pstrb[1]
        |=> phy_ctrl.force_full_duplex == $past(pwdata[BIT_FULL_DUPLEX]))
        else $error("forced duplex not taken");

    a_duplex_released: assert property (
        phy_ctrl.an_enable && !phy_stat.an_failed
        |=> !phy_ctrl.duplex_forced)
        else $error("duplex forced while negotiating");

    a_lane_low_kept: assert property (
        wr & hit_ctrl & !pstrb[0]
        |=> ctrl[7:0] == $past(ctrl[7:0]))
        else $error("low control byte written without strobe");

    a_lane_high_kept: assert property (
        wr & hit_ctrl & !pstrb[1]
        |=> ctrl[15:8] == $past(ctrl[15:8]))
        else $error("high control byte written without strobe");

    a_stat_write_ignored: assert property (
        wr & hit_stat
        |=> $stable(ctrl) && $stable(advert))
        else $error("status write changed a register");

    a_id_write_ignored: assert property (
        wr & (hit_id_low | hit_id_high)
        |=> $stable(ctrl) && $stable(advert))
        else $error("identifier write changed a register");

    a_stat_reserved_zero: assert property (
        rd_setup & hit_stat
        |=> prdata[10:7] == 4'h0 && prdata[4] == 1'b0)
        else $error("reserved status bits not zero");

    a_advert_hold: assert property (
        !(wr & hit_advert)
        |=> $stable(phy_ctrl.advert))
        else $error("advertisement changed without write");

    a_advert_readback: assert property (
        rd_setup & hit_advert
        |=> prdata[ADV_MSB:ADV_LSB] == $past(advert[ADV_MSB:ADV_LSB]))
        else $error("advertisement read wrong");

    c_layer_reset: cover property (wr & hit_reset & wdata[BIT_PHY_RESET] ##1 phy_ctrl.phy_reset);
    c_restart: cover property (phy_ctrl.an_restart);
    c_forced_mode: cover property ($fell(phy_ctrl.an_enable) ##1 phy_ctrl.duplex_forced);
    c_unmapped: cover property (pslverr);
    c_link_read: cover property (rd_setup & hit_stat ##1 prdata[BIT_LINK_UP]);

endmodule

`default_nettype wire

// *** sim/phy_layer_model.sv ***
// Behavioural physical layer facing the register bank's control and status ports.
// Assumes pclk and presetn of the bank; fail_mode comes from the bench.
`default_nettype none

module phy_layer_model
    import phy_regs_pkg::*;
#(
    parameter int DELAY = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire phy_ctrl_t phy_ctrl,
    input wire logic fail_mode,
    output var phy_stat_t phy_stat
);
    logic [7:0] count;

    // Negotiation ends DELAY cycles after a restart; a layer reset drops the link
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            phy_stat <= '0;
        end else if (phy_ctrl.phy_reset) begin
            count <= '0;
            phy_stat <= '0;
        end else if (phy_ctrl.an_restart) begin
            count <= 8'(DELAY);
            phy_stat <= '0;
        end else if (count == 8'h01) begin
            count <= '0;
            phy_stat <= '{link_up: !fail_mode, an_complete: !fail_mode, an_failed: fail_mode};
        end else if (count != 8'h00) begin
            count <= count - 8'h01;
        end
    end
endmodule

`default_nettype wire

// *** sim/phy_mii_control_status_regs_tb.sv ***
// Self-checking bench for the physical-layer register bank.
// Assumes phy_layer_model on the layer side and a zero-wait APB slave.
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module phy_mii_control_status_regs_tb
    import phy_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Identifier values are arbitrary
    localparam logic [15:0] ID_LO = 16'h1234;
    localparam logic [15:0] ID_HI = 16'h0456;
    typedef struct {logic w; logic [ADDR_W-1:0] a; logic [15:0] d; logic [31:0] r; logic e;} row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fail_mode = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = '0;
    logic [3:0] strb = 4'h3;
    logic [15:0] d;
    logic pready, pslverr, er;
    phy_ctrl_t ctrl;
    phy_stat_t stat;
    int bad_count = 0, tests_run = 0, np, nr;
    row_t rows[12] = '{
        '{0, ADDR_CTRL, 0, 32'h0000_3120, 0}, '{0, ADDR_STAT, 0, 32'h0000_7808, 0},
        '{0, ADDR_ID_LOW, 0, {16'h0000, ID_LO}, 0}, '{0, ADDR_ID_HIGH, 0, {16'h0000, ID_HI}, 0},
        '{0, ADDR_ADVERT, 0, 32'h0000_05e1, 0}, '{0, ADDR_RESET, 0, 32'h0000_fffe, 0},
        '{1, ADDR_ADVERT, 16'hffff, 0, 0}, '{0, ADDR_ADVERT, 0, 32'h0000_07e1, 0},
        '{1, ADDR_STAT, 16'h0000, 0, 0}, '{0, ADDR_STAT, 0, 32'h0000_7808, 0},
        '{1, 12'h004, 16'hffff, 0, 1}, '{0, 12'h004, 0, 0, 1}};

    always #50 pclk = ~pclk;

    phy_mii_control_status_regs #(.PHY_ID_LOW(ID_LO), .PHY_ID_HIGH(ID_HI)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .phy_ctrl(ctrl), .phy_stat(stat));
    phy_layer_model model (.pclk(pclk), .presetn(presetn), .phy_ctrl(ctrl), .fail_mode(fail_mode),
        .phy_stat(stat));

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] v,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, v};
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // Counts layer reset and restart pulses over the three cycles after a write
    task automatic pulses;
        np = 0;
        nr = 0;
        repeat (3) begin
            #1;
            np += int'(ctrl.phy_reset === 1'b1);
            nr += int'(ctrl.an_restart === 1'b1);
            @(posedge pclk);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge pclk);
        bad_count++;
        end_sim;
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
            if (!rows[i].w) `CHK(rd, rows[i].r)
            `CHK(er, rows[i].e)
        end
        $display("test register table done");
        for (int b = 0; b < 16; b++) begin
            d = 16'h0001 << b;
            apb(1, ADDR_CTRL, d, rd, er);
            pulses;
            `CHK({ctrl.loopback, ctrl.force_speed_100, ctrl.an_enable, ctrl.force_full_duplex, ctrl.crossover_algorithm_select, ctrl.force_mdix, ctrl.disable_auto_mdix, ctrl.tx_disable, ctrl.led_disable}, {d[14], d[13], d[12], d[8], d[5], d[4], d[3], d[1], d[0]})
            `CHK({ctrl.speed_forced, ctrl.duplex_forced, nr == 1}, {~d[12], ~d[12], d[9]})
            apb(0, ADDR_CTRL, 16'h0000, rd, er);
            `CHK(rd, {16'h0000, d & 16'h7d3f})
        end
        $display("test control bits done");
        fail_mode <= 1;
        apb(1, ADDR_CTRL, 16'h1200, rd, er);
        repeat (8) @(posedge pclk);
        apb(0, ADDR_STAT, 16'h0000, rd, er);
        `CHK({rd, ctrl.duplex_forced}, {32'h0000_7808, 1'b1})
        fail_mode <= 0;
        apb(1, ADDR_CTRL, 16'h1200, rd, er);
        repeat (8) @(posedge pclk);
        apb(0, ADDR_STAT, 16'h0000, rd, er);
        `CHK({rd, ctrl.duplex_forced}, {32'h0000_782c, 1'b0})
        $display("test negotiation done");
        apb(1, ADDR_RESET, 16'h0001, rd, er);
        pulses;
        `CHK(np == 1, 1'b1)
        apb(0, ADDR_STAT, 16'h0000, rd, er);
        `CHK(rd, 32'h0000_7808)
        apb(0, ADDR_RESET, 16'h0000, rd, er);
        `CHK(rd, 32'h0000_0000)
        apb(1, ADDR_ADVERT, 16'h0520, rd, er);
        pulses;
        `CHK(ctrl.advert, 6'h29)
        $display("test layer reset and advert done");
        presetn <= 0;
        @(posedge pclk);
        #1;
        `CHK({ctrl.advert, ctrl.an_enable, ctrl.loopback}, {6'h2f, 1'b1, 1'b0})
        @(posedge pclk);
        presetn <= 1;
        apb(0, ADDR_CTRL, 16'h0000, rd, er);
        `CHK(rd, 32'h0000_3120)
        $display("test mid-run reset done");
        strb = 4'h1;
        apb(1, ADDR_CTRL, 16'hffff, rd, er);
        apb(0, ADDR_CTRL, 16'h0000, rd, er);
        `CHK(rd, 32'h0000_313f)
        strb = 4'h2;
        apb(1, ADDR_CTRL, 16'h0000, rd, er);
        apb(0, ADDR_CTRL, 16'h0000, rd, er);
        `CHK(rd, 32'h0000_003f)
        strb = 4'h3;
        $display("test byte lanes done");
        end_sim;
    end
endmodule

`default_nettype wire
